// file: dv/wdcm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module wdcm_pin_model (
   // Clock
   input wire logic pclk,
   // Design drive of the fault pin
   input wire logic fault_pin_o,
   input wire logic fault_pin_oe,
   // Heavy load: pin falls 8 cycles late
   input wire logic slow,
   // Resolved pin level
   output logic pin_level
);
   logic [3:0] fall_ff;

   always_ff @(posedge pclk)
   begin
      if (!fault_pin_oe)
         fall_ff <= 4'h0;
      else if (fall_ff != 4'hF)
         fall_ff <= fall_ff + 4'h1;
   end

   // Weak pull-up wins whenever the pin is not driven
   assign pin_level = (fault_pin_oe && (!slow || fall_ff >= 4'h8)) ? fault_pin_o : 1'b1;
endmodule : wdcm_pin_model

`default_nettype wire

// file: dv/wdcm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module wdcm_top_tb;
   localparam int GAP = 50;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic inst_tick = 1'b0;
   logic halt_mode = 1'b0;
   logic idle_mode = 1'b0;
   logic slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic fault_pin_o;
   logic fault_pin_oe;
   logic pin_level;
   logic [31:0] rd;
   logic er;
   logic [31:0] tv [4];
   int errors = 0;
   int checks_done = 0;
   int n;
   int lim;

   always #5 pclk = ~pclk;

   wdcm_top #(.CM_GAP_CYC(GAP)) wdcm_top_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .inst_tick(inst_tick),
      .halt_mode(halt_mode), .idle_mode(idle_mode), .fault_pin_i(pin_level),
      .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe));

   wdcm_pin_model wdcm_pin_model_i (.pclk(pclk), .fault_pin_o(fault_pin_o),
      .fault_pin_oe(fault_pin_oe), .slow(slow), .pin_level(pin_level));

   function automatic logic [31:0] svc(input logic [1:0] sel, input logic [4:0] key,
      input logic cm);
      return {24'h00_0000, sel, key, cm};
   endfunction : svc

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input int v, input int lo, input int hi);
      checks_done++;
      if (v < lo || v > hi)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, v, lo, hi);
      end
   endtask : chk_rng

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50)
      begin
         @(posedge pclk);
         k++;
      end
      if (k == 50)
         errors++;
      // Answer taken at the edge where pready is sampled high
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_oe(input logic v, input int lm);
      n = 0;
      @(negedge pclk);
      while (fault_pin_oe !== v && n < lm)
      begin
         @(negedge pclk);
         n++;
      end
   endtask : wait_oe

   task automatic pulse();
      wait_oe(1'b1, 10);
      chk_rng(n, 0, 9);
      chk({31'h0000_0000, fault_pin_o}, 32'h0000_0000);
      wait_oe(1'b0, 80);
      chk_rng(n, 16, 45);
   endtask : pulse

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   initial
   begin
      #(100_000 * 10);
      errors++;
      conclude();
   end

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      inst_tick <= 1'b1;
      apb(1'b0, wdcm_pkg::SVC_OFS, 32'h0);
      chk(rd, svc(wdcm_pkg::SEL_RST, 5'h00, wdcm_pkg::CM_RST));
      apb(1'b0, wdcm_pkg::CFG_OFS, 32'h0);
      chk(rd, {29'h0, wdcm_pkg::CFG_RST});
      $display("test reset done");
      apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'h0, wdcm_pkg::KEY_VAL, 1'b1));
      wait_oe(1'b1, 20);
      chk_rng(n, 20, 20);
      apb(1'b0, wdcm_pkg::SVC_OFS, 32'h0);
      chk(rd, svc(2'h0, 5'h00, 1'b1));
      apb(1'b0, wdcm_pkg::STS_OFS, 32'h0);
      chk({31'h0, rd[3]}, 32'h0000_0001);
      $display("test first done");
      repeat (100) @(posedge pclk);
      apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'h0, wdcm_pkg::KEY_VAL, 1'b1));
      // Bad write lands while the pulse is active and must not count
      apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'h1, 5'h00, 1'b0));
      pulse();
      wait_oe(1'b1, 20);
      chk_rng(n, 20, 20);
      $display("test early done");
      tv = '{svc(2'h0, wdcm_pkg::KEY_VAL, 1'b1), svc(2'h0, wdcm_pkg::KEY_VAL ^ 5'h01, 1'b1),
         svc(2'h1, wdcm_pkg::KEY_VAL, 1'b1), svc(2'h0, wdcm_pkg::KEY_VAL, 1'b0)};
      for (int i = 0; i < 4; i++)
      begin
         repeat (2100) @(posedge pclk);
         slow <= (i == 2);
         apb(1'b1, wdcm_pkg::SVC_OFS, tv[i]);
         if (i == 0)
         begin
            wait_oe(1'b1, 20);
            chk_rng(n, 20, 20);
         end
         else
            pulse();
      end
      @(posedge pclk);
      slow <= 1'b0;
      $display("test fields done");
      inst_tick <= 1'b0;
      wait_oe(1'b1, GAP + 20);
      chk_rng(n, GAP - 2, GAP + 5);
      @(posedge pclk);
      inst_tick <= 1'b1;
      wait_oe(1'b0, 80);
      chk_rng(n, 16, 40);
      $display("test monitor done");
      // Idle exit, halt with resume, halt with restart
      for (int m = 0; m < 3; m++)
      begin
         apb(1'b1, wdcm_pkg::CFG_OFS, (m == 1) ? 32'h0000_0001 : 32'h0000_0000);
         repeat (2100) @(posedge pclk);
         if (m == 0)
            idle_mode <= 1'b1;
         else
            halt_mode <= 1'b1;
         repeat (50) @(posedge pclk);
         idle_mode <= 1'b0;
         halt_mode <= 1'b0;
         apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'h0, wdcm_pkg::KEY_VAL, 1'b1));
         if (m == 1)
         begin
            wait_oe(1'b1, 20);
            chk_rng(n, 20, 20);
         end
         else
            pulse();
      end
      $display("test low power done");
      apb(1'b0, 8'h0C, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, wdcm_pkg::CFG_OFS, 32'h0000_0004);
      apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'h0, 5'h00, 1'b1));
      wait_oe(1'b1, 20);
      chk_rng(n, 20, 20);
      $display("test access done");
      for (int s = 0; s < 3; s++)
      begin
         do_reset();
         lim = int'(wdcm_pkg::UPPER_BASE) << s;
         apb(1'b1, wdcm_pkg::SVC_OFS, svc(2'(s), wdcm_pkg::KEY_VAL, 1'b1));
         wait_oe(1'b1, lim + 40);
         chk_rng(n, lim - 10, lim + 10);
         wait_oe(1'b0, 80);
         chk_rng(n, 16, 45);
      end
      $display("test timeout done");
      conclude();
   end
endmodule : wdcm_top_tb

`default_nettype wire

// file: rtl/wdcm_pkg.sv
package wdcm_pkg;
   // Register byte offsets
   localparam logic [7:0] SVC_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] STS_OFS = 8'h08;
   // Service register fields
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam int KEY_HI = 5;
   localparam int KEY_LO = 1;
   localparam int CM_BIT = 0;
   localparam logic [4:0] KEY_VAL = 5'h0C;
   localparam logic [1:0] SEL_RST = 2'h3;
   localparam logic CM_RST = 1'b1;
   // Option register fields
   localparam int CFG_RC_BIT = 0;
   localparam int CFG_DLY_BIT = 1;
   localparam int CFG_DIS_BIT = 2;
   localparam logic [2:0] CFG_RST = 3'h0;
   // Window limits and fault hold length in instruction cycles
   localparam logic [16:0] LOWER_CYC = 17'h0_0800;
   localparam logic [16:0] UPPER_BASE = 17'h0_2000;
   localparam logic [4:0] HOLD_TICKS = 5'h10;
   // Clock monitor slow-clock timeout
   localparam int CLK_MHZ = 100;
   localparam int CM_TIMEOUT_US = 1000;
   localparam int CM_TIMEOUT_CYC = CM_TIMEOUT_US * CLK_MHZ;

   typedef enum logic [1:0] {FLT_IDLE, FLT_DRIVE, FLT_HOLD, FLT_REL} wdcm_fault_type;

   function automatic logic [16:0] upper_lim(input logic [1:0] sel);
      return 17'(UPPER_BASE << sel);
   endfunction : upper_lim
endpackage : wdcm_pkg

// file: rtl/wdcm_top.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - Service earlier than 2048 instruction cycles into the window is an error
// R2 - Bits 7:6 select upper limit 8k, 16k, 32k or 64k cycles
// R3 - Key bits 5:1 must be 01100, any other key is an error
// R4 - Service register holds window select, key and clock monitor enable
// R5 - Watchdog works only while option bit 2 is zero; drives fault pin
// R6 - Reset inhibits detectors and loads maximum window with monitor enabled
// R7 - First matching write after reset fixes window and monitor choice
// R8 - Later services must match all fields, otherwise an error
// R9 - No service before the upper limit gives an error
// R10 - Software services at most once per lower-limit interval
// R11 - Fault pin held low 16 cycles after pin reads low, then released
// R12 - Window restarts when fault pin returns high
// R13 - Service writes during an active fault pulse are ignored
// R14 - Slow clock holds pin low until 16 cycles after recovery
// R15 - Monitor accepts 10 kHz and above, rejects below 10 Hz
// R16 - Key field always reads as zeros
// R17 - Watchdog paused in low-power modes; monitor keeps running
// R18 - RC option without delay resumes window count after clock stop
// R19 - Crystal or delayed RC restarts the window after clock stop
// R20 - Leaving idle mode performs an automatic service
// R21 - First service after reset has no lower-limit check
// R22 - Watchdog and clock errors share one fault pin
// R23 - Window counter counts instruction cycles, checked on every service after the first
module wdcm_top #(
   parameter int unsigned CM_GAP_CYC = wdcm_pkg::CM_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core status
   input wire logic inst_tick,
   input wire logic halt_mode,
   input wire logic idle_mode,
   // Open-drain fault pin
   input wire logic fault_pin_i,
   output logic fault_pin_o,
   output logic fault_pin_oe
);

   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [31:0] prdata_ff, nxt_prdata;
   logic [2:0] cfg_ff, nxt_cfg;
   logic [1:0] sel_ff, nxt_sel;
   logic cm_en_ff, nxt_cm_en;
   logic first_ff, nxt_first;
   logic [16:0] win_cnt_ff, nxt_win_cnt;
   logic [4:0] hold_cnt_ff, nxt_hold_cnt;
   wdcm_pkg::wdcm_fault_type st_ff, nxt_st;
   logic idle_d_ff, halt_d_ff;
   logic [23:0] gap_ff, nxt_gap;
   logic slow_ff, nxt_slow;
   logic [4:0] rec_ff, nxt_rec;
   logic pin_meta_ff, pin_sync_ff;
   logic oe_ff, nxt_oe;
   logic pin_o_ff;

   logic apb_acc, svc_wr, cfg_wr;
   logic wd_on, key_ok, svc_eval, svc_bad, run, timeout;
   logic halt_exit, idle_exit, resume_cnt;

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign fault_pin_o = pin_o_ff;
   assign fault_pin_oe = oe_ff;

   assign apb_acc = clk_en & psel & penable & pready_ff;
   assign svc_wr = apb_acc & pwrite & (paddr == wdcm_pkg::SVC_OFS);
   assign cfg_wr = apb_acc & pwrite & (paddr == wdcm_pkg::CFG_OFS);

   // Register read path, answered one cycle after setup
   always_comb
   begin
      nxt_pready = psel & ~penable;
      nxt_pslverr = 1'b0;
      nxt_prdata = prdata_ff;
      nxt_cfg = cfg_ff;
      if (psel & ~penable)
      begin
         unique case (paddr)
            wdcm_pkg::SVC_OFS:
               nxt_prdata = {24'h00_0000, sel_ff, 5'h00, cm_en_ff}; // see R16
            wdcm_pkg::CFG_OFS:
               nxt_prdata = {29'h0000_0000, cfg_ff};
            wdcm_pkg::STS_OFS:
               nxt_prdata = {27'h000_0000, slow_ff, first_ff, st_ff != wdcm_pkg::FLT_IDLE,
                             oe_ff, pin_sync_ff};
            default:
            begin
               nxt_prdata = 32'h0000_0000;
               nxt_pslverr = 1'b1;
            end
         endcase
      end
      if (cfg_wr)
      begin
         nxt_cfg = pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         cfg_ff <= wdcm_pkg::CFG_RST;
      end
      else if (clk_en)
      begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
         cfg_ff <= nxt_cfg;
      end
   end

   // Watchdog window and fault pulse
   assign wd_on = ~cfg_ff[wdcm_pkg::CFG_DIS_BIT]; // see R5
   assign key_ok = pwdata[wdcm_pkg::KEY_HI:wdcm_pkg::KEY_LO] == wdcm_pkg::KEY_VAL; // see R3
   assign svc_eval = svc_wr & wd_on & (st_ff == wdcm_pkg::FLT_IDLE); // see R13
   assign svc_bad = ~key_ok | (first_ff &
      ((pwdata[wdcm_pkg::SEL_HI:wdcm_pkg::SEL_LO] != sel_ff) |
       (pwdata[wdcm_pkg::CM_BIT] != cm_en_ff) |
       (win_cnt_ff < wdcm_pkg::LOWER_CYC))); // see R1 R8 R21
   assign run = wd_on & ~halt_mode & ~idle_mode & (st_ff == wdcm_pkg::FLT_IDLE); // see R17
   assign timeout = run & inst_tick &
      (win_cnt_ff >= 17'(wdcm_pkg::upper_lim(sel_ff) - 17'h0_0001)); // see R2 R9
   assign halt_exit = halt_d_ff & ~halt_mode;
   assign idle_exit = idle_d_ff & ~idle_mode;
   assign resume_cnt = cfg_ff[wdcm_pkg::CFG_RC_BIT] & ~cfg_ff[wdcm_pkg::CFG_DLY_BIT];

   always_comb
   begin
      nxt_st = st_ff;
      nxt_win_cnt = win_cnt_ff;
      nxt_hold_cnt = hold_cnt_ff;
      nxt_sel = sel_ff;
      nxt_cm_en = cm_en_ff;
      nxt_first = first_ff;
      if (run & inst_tick)
      begin
         nxt_win_cnt = 17'(win_cnt_ff + 17'h0_0001); // see R23
      end
      if (halt_exit & ~resume_cnt)
      begin
         nxt_win_cnt = 17'h0_0000; // see R18 R19
      end
      if (idle_exit)
      begin
         nxt_win_cnt = 17'h0_0000; // see R20
      end
      if (svc_eval)
      begin
         if (svc_bad)
         begin
            nxt_st = wdcm_pkg::FLT_DRIVE;
         end
         else
         begin
            nxt_win_cnt = 17'h0_0000;
            if (!first_ff)
            begin
               nxt_sel = pwdata[wdcm_pkg::SEL_HI:wdcm_pkg::SEL_LO]; // see R4 R7
               nxt_cm_en = pwdata[wdcm_pkg::CM_BIT];
               nxt_first = 1'b1;
            end
         end
      end
      if (timeout)
      begin
         nxt_st = wdcm_pkg::FLT_DRIVE;
      end
      unique case (st_ff)
         wdcm_pkg::FLT_IDLE:
         begin
         end
         wdcm_pkg::FLT_DRIVE:
         begin
            if (!pin_sync_ff)
            begin
               nxt_st = wdcm_pkg::FLT_HOLD;
               nxt_hold_cnt = 5'h00;
            end
         end
         wdcm_pkg::FLT_HOLD:
         begin
            if (inst_tick)
            begin
               nxt_hold_cnt = 5'(hold_cnt_ff + 5'h01);
               if (hold_cnt_ff == 5'(wdcm_pkg::HOLD_TICKS - 5'h01))
               begin
                  nxt_st = wdcm_pkg::FLT_REL; // see R11
               end
            end
         end
         wdcm_pkg::FLT_REL:
         begin
            if (pin_sync_ff)
            begin
               nxt_st = wdcm_pkg::FLT_IDLE;
               nxt_win_cnt = 17'h0_0000; // see R12
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= wdcm_pkg::FLT_IDLE;
         win_cnt_ff <= 17'h0_0000;
         hold_cnt_ff <= 5'h00;
         sel_ff <= wdcm_pkg::SEL_RST; // see R6
         cm_en_ff <= wdcm_pkg::CM_RST;
         first_ff <= 1'b0;
         idle_d_ff <= 1'b0;
         halt_d_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         st_ff <= nxt_st;
         win_cnt_ff <= nxt_win_cnt;
         hold_cnt_ff <= nxt_hold_cnt;
         sel_ff <= nxt_sel;
         cm_en_ff <= nxt_cm_en;
         first_ff <= nxt_first;
         idle_d_ff <= idle_mode;
         halt_d_ff <= halt_mode;
      end
   end

   // Clock monitor: gap between instruction ticks in bus clocks
   always_comb
   begin
      nxt_gap = gap_ff;
      nxt_slow = slow_ff;
      nxt_rec = rec_ff;
      if (inst_tick)
      begin
         nxt_gap = 24'h00_0000;
      end
      else if (gap_ff != 24'(CM_GAP_CYC - 1))
      begin
         nxt_gap = 24'(gap_ff + 24'h00_0001);
      end
      if (!inst_tick && gap_ff == 24'(CM_GAP_CYC - 1))
      begin
         nxt_slow = 1'b1; // see R15 R17
         nxt_rec = 5'h00;
      end
      else if (slow_ff && inst_tick)
      begin
         nxt_rec = 5'(rec_ff + 5'h01);
         if (rec_ff == 5'(wdcm_pkg::HOLD_TICKS - 5'h01))
         begin
            nxt_slow = 1'b0; // see R14
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_ff <= 24'h00_0000;
         slow_ff <= 1'b0;
         rec_ff <= 5'h00;
      end
      else if (clk_en)
      begin
         gap_ff <= nxt_gap;
         slow_ff <= nxt_slow;
         rec_ff <= nxt_rec;
      end
   end

   // Shared fault pin; driven only low, pull-up gives the high level
   assign nxt_oe = (st_ff == wdcm_pkg::FLT_DRIVE) | (st_ff == wdcm_pkg::FLT_HOLD) |
                   (cm_en_ff & slow_ff); // see R22 R14

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oe_ff <= 1'b0;
         pin_o_ff <= 1'b0;
         pin_meta_ff <= 1'b1;
         pin_sync_ff <= 1'b1;
      end
      else if (clk_en)
      begin
         oe_ff <= nxt_oe;
         pin_o_ff <= 1'b0;
         pin_meta_ff <= fault_pin_i;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_hold_last;
      clk_en && st_ff == wdcm_pkg::FLT_HOLD && inst_tick &&
      hold_cnt_ff == 5'(wdcm_pkg::HOLD_TICKS - 5'h01);
   endsequence

   sequence s_release;
      st_ff == wdcm_pkg::FLT_REL ##1 (!oe_ff || (cm_en_ff && slow_ff));
   endsequence

   a_early_service: assert property ( // see R1
      svc_eval && first_ff && key_ok && win_cnt_ff < wdcm_pkg::LOWER_CYC
      |=> st_ff == wdcm_pkg::FLT_DRIVE ##1 oe_ff)
      else $error("early service not flagged");

   a_window_load: assert property ( // see R2
      svc_eval && !first_ff && key_ok
      |=> sel_ff == $past(pwdata[7:6]) && first_ff)
      else $error("window select not loaded");

   a_bad_key: assert property ( // see R3
      svc_eval && !key_ok |=> st_ff == wdcm_pkg::FLT_DRIVE)
      else $error("bad key not flagged");

   a_choice_locked: assert property ( // see R7
      first_ff |=> first_ff && $stable(sel_ff) && $stable(cm_en_ff))
      else $error("window choice changed");

   a_key_reads_zero: assert property ( // see R16
      pready_ff && psel && !pwrite && paddr == wdcm_pkg::SVC_OFS |-> prdata_ff[5:1] == 5'h00)
      else $error("key field not zero");

   a_disabled_quiet: assert property ( // see R5
      !wd_on && st_ff == wdcm_pkg::FLT_IDLE |=> st_ff == wdcm_pkg::FLT_IDLE)
      else $error("watchdog acted while disabled");

   a_upper_timeout: assert property ( // see R9
      clk_en && run && inst_tick && win_cnt_ff == 17'(wdcm_pkg::upper_lim(sel_ff) - 17'h0_0001)
      |=> st_ff == wdcm_pkg::FLT_DRIVE)
      else $error("upper limit missed");

   a_hold_release: assert property ( // see R11
      s_hold_last |=> s_release)
      else $error("fault pulse not released");

   a_busy_ignored: assert property ( // see R13
      svc_wr && st_ff != wdcm_pkg::FLT_IDLE |=> $stable(first_ff) && $stable(sel_ff))
      else $error("service taken during fault");

   a_clock_fault_pin: assert property ( // see R14
      clk_en && cm_en_ff && slow_ff |=> oe_ff)
      else $error("clock fault not driven");

   a_restart_on_high: assert property ( // see R12
      clk_en && st_ff == wdcm_pkg::FLT_REL && pin_sync_ff
      |=> st_ff == wdcm_pkg::FLT_IDLE && win_cnt_ff == 17'h0_0000)
      else $error("window not restarted");

endmodule : wdcm_top

`default_nettype wire
